// file: hw/dio_io_ports.sv
// Three eight-bit open-collector I/O ports with Port C and external interrupts, AXI4-Lite slave
module dio_io_ports
    import dio_pkg::*;
#(
    parameter int unsigned CHANNELS = 8
)
(
    input wire logic core_clk, // 200 MHz clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [3:0] s_axi_awaddr, // Write address, byte
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [3:0] s_axi_araddr, // Read address, byte
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire dio_ports_s portIn, // Channel pin levels
    output dio_ports_s portOut, // Channel driver output, always zero
    output dio_ports_s portOe, // Channel driver on (sinks low)
    input wire logic extIrqIn, // External interrupt pin
    output logic irq // Interrupt, level, active high
);

    localparam int unsigned PORTS_W = 3 * CHANNELS;

    dio_ports_s latch_q;
    dio_irq_cfg_s cfg_q;
    logic [CHANNELS-1:0] portCPending;
    logic extPending;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic irq_q;
    logic [PORTS_W-1:0] sync1_q;
    logic [PORTS_W-1:0] sync2_q;
    logic [PORTS_W-1:0] sync3_q;
    logic [PORTS_W-1:0] pinLevel_q;
    logic extSync1_q;
    logic extSync2_q;
    logic extSync3_q;
    logic extLevel_q;
    logic extLevelPrev_q;
    logic [CHANNELS-1:0] portCPrev_q;
    dio_ports_s oe_q;

    logic [3:0] awaddr_q;
    logic awHeld_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wHeld_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic doWrite;
    logic wrLane0;
    logic [7:0] wrByte;
    logic [CHANNELS-1:0] portCAck;
    logic extAck;
    logic [1:0] statEvent;
    logic [1:0] pendingPrev_q;
    logic [31:0] rdValue;
    logic rdHit;
    dio_ports_s readPorts;

    // Write channel: address and data taken independently, response once both held
    assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
    assign wrLane0 = doWrite && wstrb_q[0];
    assign wrByte = wdata_q[7:0];

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            awHeld_q <= 1'b0;
            awaddr_q <= 4'h0;
        end
        else if (s_axi_awvalid && !awHeld_q)
        begin
            awHeld_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        else if (doWrite)
            awHeld_q <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wHeld_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else if (s_axi_wvalid && !wHeld_q)
        begin
            wHeld_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        else if (doWrite)
            wHeld_q <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (doWrite)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= rdHitW(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    function automatic logic rdHitW(input logic [3:0] a);
        rdHitW = (a == ADDR_PORT_A) || (a == ADDR_PORT_B) || (a == ADDR_PORT_C)
            || (a == ADDR_PORT_C_ALLOW) || (a == ADDR_MODE_CTRL)
            || (a == ADDR_PORT_C_PENDING) || (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
    endfunction : rdHitW

    assign s_axi_awready = !awHeld_q;
    assign s_axi_wready = !wHeld_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Latches: one releases the channel, zero drives it low
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            latch_q <= '{portA: LATCH_RESET, portB: LATCH_RESET, portC: LATCH_RESET};
        else if (wrLane0)
        begin
            if (awaddr_q == ADDR_PORT_A)
                latch_q.portA <= wrByte;
            if (awaddr_q == ADDR_PORT_B)
                latch_q.portB <= wrByte;
            if (awaddr_q == ADDR_PORT_C)
                latch_q.portC <= wrByte;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            oe_q <= '0;
        else
            oe_q <= ~latch_q;
    end

    assign portOe = oe_q;
    assign portOut = '0;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            cfg_q <= '{portCAllow: BYTE_RESET, extAllow: 1'b0, extTrig: dio_trig_e'(TRIG_RESET),
                highTrig: dio_trig_e'(TRIG_RESET), lowTrig: dio_trig_e'(TRIG_RESET)};
        else if (wrLane0)
        begin
            if (awaddr_q == ADDR_PORT_C_ALLOW)
                cfg_q.portCAllow <= wrByte;
            if (awaddr_q == ADDR_MODE_CTRL)
            begin
                cfg_q.extAllow <= wrByte[EXT_ALLOW_BIT];
                cfg_q.extTrig <= dio_trig_e'(wrByte[EXT_TRIG_LSB +: 2]);
                cfg_q.highTrig <= dio_trig_e'(wrByte[HIGH_TRIG_LSB +: 2]);
                cfg_q.lowTrig <= dio_trig_e'(wrByte[LOW_TRIG_LSB +: 2]);
            end
        end
    end

    // Three-stage synchronisers; a change counts when stages two and three agree
    // Channel stages reset high, the pull-up idle level, so no false edge follows reset
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            sync1_q <= '1;
            sync2_q <= '1;
            sync3_q <= '1;
            pinLevel_q <= '1;
            extSync1_q <= 1'b0;
            extSync2_q <= 1'b0;
            extSync3_q <= 1'b0;
            extLevel_q <= 1'b0;
        end
        else
        begin
            sync1_q <= portIn;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pinLevel_q <= (sync2_q & sync3_q) | (pinLevel_q & (sync2_q | sync3_q));
            extSync1_q <= extIrqIn;
            extSync2_q <= extSync1_q;
            extSync3_q <= extSync2_q;
            extLevel_q <= (extSync2_q && extSync3_q) || (extLevel_q && (extSync2_q || extSync3_q));
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            portCPrev_q <= '1;
            extLevelPrev_q <= 1'b0;
        end
        else
        begin
            portCPrev_q <= pinLevel_q[CHANNELS-1:0];
            extLevelPrev_q <= extLevel_q;
        end
    end

    // Acknowledge masks from writes at the pending offset and mode control bit 7
    assign portCAck = (wrLane0 && awaddr_q == ADDR_PORT_C_PENDING) ? wrByte : '0;
    assign extAck = wrLane0 && awaddr_q == ADDR_MODE_CTRL && wrByte[EXT_PENDING_BIT];

    // Port C channels: input only where latch released; interrupt view keeps data readable
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : gen_port_c_irq
            dio_trigger u_trigger (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .level(pinLevel_q[ch]),
                .levelPrev(portCPrev_q[ch]),
                .allow(cfg_q.portCAllow[ch] && latch_q.portC[ch]),
                .trig(ch >= CHANNELS / 2 ? cfg_q.highTrig : cfg_q.lowTrig),
                .ack(portCAck[ch]),
                .pending(portCPending[ch])
            );
        end
    endgenerate

    dio_trigger u_ext_trigger (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .level(extLevel_q),
        .levelPrev(extLevelPrev_q),
        .allow(cfg_q.extAllow),
        .trig(cfg_q.extTrig),
        .ack(extAck),
        .pending(extPending)
    );

    // Block status: sticky bits set on rising pending, write-one clears, set wins
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            pendingPrev_q <= STAT_RESET;
        else
            pendingPrev_q <= {extPending, |portCPending};
    end

    assign statEvent = {extPending, |portCPending} & ~pendingPrev_q;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            stat_q <= STAT_RESET;
        else if (wrLane0 && awaddr_q == ADDR_IRQ_STATUS)
            stat_q <= statEvent | (stat_q & ~wrByte[1:0]);
        else
            stat_q <= stat_q | statEvent;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            mask_q <= 2'h3;
        else if (wrLane0 && awaddr_q == ADDR_IRQ_MASK)
            mask_q <= wrByte[1:0];
    end

    // Level interrupt follows live pending state, so after an acknowledge it stays high only while an unmasked pending bit remains
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            irq_q <= 1'b0;
        else
            irq_q <= (mask_q[STAT_PORT_C_BIT] && |portCPending)
                || (mask_q[STAT_EXT_BIT] && extPending);
    end

    assign irq = irq_q;

    // Read path; channels whose latch drives them low read zero
    assign readPorts = pinLevel_q & latch_q;

    always_comb
    begin
        rdHit = 1'b1;
        rdValue = 32'h0000_0000;
        case (s_axi_araddr)
            ADDR_PORT_A: rdValue[7:0] = readPorts.portA;
            ADDR_PORT_B: rdValue[7:0] = readPorts.portB;
            ADDR_PORT_C: rdValue[7:0] = readPorts.portC;
            ADDR_PORT_C_ALLOW: rdValue[7:0] = cfg_q.portCAllow;
            ADDR_MODE_CTRL: rdValue[7:0] = {extPending, cfg_q.extAllow, cfg_q.extTrig,
                cfg_q.highTrig, cfg_q.lowTrig};
            ADDR_PORT_C_PENDING: rdValue[7:0] = portCPending;
            ADDR_IRQ_STATUS: rdValue[1:0] = stat_q;
            ADDR_IRQ_MASK: rdValue[1:0] = mask_q;
            default: rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rdValue;
            rresp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule : dio_io_ports

// file: hw/dio_pkg.sv
// Package with register map, field positions and carrier types for the digital I/O block
package dio_pkg;

    // Register byte addresses: printed offsets 0..7 are not multiples of four, yet each index is used unscaled as its address
    localparam int unsigned PORT_A_IDX = 0;
    localparam int unsigned PORT_B_IDX = 1;
    localparam int unsigned PORT_C_IDX = 2;
    localparam int unsigned PORT_C_ALLOW_IDX = 5;
    localparam int unsigned MODE_CTRL_IDX = 6;
    localparam int unsigned PORT_C_PENDING_IDX = 7;
    localparam int unsigned IRQ_STATUS_IDX = 8;
    localparam int unsigned IRQ_MASK_IDX = 9;

    localparam logic [3:0] ADDR_PORT_A = 4'(PORT_A_IDX);
    localparam logic [3:0] ADDR_PORT_B = 4'(PORT_B_IDX);
    localparam logic [3:0] ADDR_PORT_C = 4'(PORT_C_IDX);
    localparam logic [3:0] ADDR_PORT_C_ALLOW = 4'(PORT_C_ALLOW_IDX);
    localparam logic [3:0] ADDR_MODE_CTRL = 4'(MODE_CTRL_IDX);
    localparam logic [3:0] ADDR_PORT_C_PENDING = 4'(PORT_C_PENDING_IDX);
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'(IRQ_STATUS_IDX);
    localparam logic [3:0] ADDR_IRQ_MASK = 4'(IRQ_MASK_IDX);

    // Mode control register field positions
    localparam int unsigned EXT_PENDING_BIT = 7;
    localparam int unsigned EXT_ALLOW_BIT = 6;
    localparam int unsigned EXT_TRIG_LSB = 4;
    localparam int unsigned HIGH_TRIG_LSB = 2;
    localparam int unsigned LOW_TRIG_LSB = 0;

    // Block status register: bit 0 Port C pending, bit 1 external pending
    localparam int unsigned STAT_PORT_C_BIT = 0;
    localparam int unsigned STAT_EXT_BIT = 1;

    // Reset values: latches released so every channel reads as an input
    localparam logic [7:0] LATCH_RESET = 8'hFF;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] TRIG_RESET = 2'h0;
    localparam logic [1:0] STAT_RESET = 2'h0;

    localparam int unsigned SYNC_STAGES = 3;

    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        TRIG_LEVEL_LOW = 2'b00,
        TRIG_LEVEL_HIGH = 2'b01,
        TRIG_FALL = 2'b10,
        TRIG_RISE = 2'b11
    } dio_trig_e;

    typedef struct packed {
        logic [7:0] portA;
        logic [7:0] portB;
        logic [7:0] portC;
    } dio_ports_s;

    typedef struct packed {
        logic [7:0] portCAllow;
        logic extAllow;
        dio_trig_e extTrig;
        dio_trig_e highTrig;
        dio_trig_e lowTrig;
    } dio_irq_cfg_s;

endpackage : dio_pkg

// file: hw/dio_trigger.sv
// One interrupt channel: trigger detection and sticky pending bit with acknowledge
module dio_trigger
    import dio_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic level, // Synchronised input level
    input wire logic levelPrev, // Level one cycle earlier
    input wire logic allow, // Channel may raise its pending bit
    input wire dio_trig_e trig, // Trigger mode
    input wire logic ack, // Write-one acknowledge pulse
    output logic pending // Sticky pending bit
);

    logic cond;
    logic pending_q;

    always_comb
    begin
        case (trig)
            TRIG_LEVEL_LOW: cond = !level;
            TRIG_LEVEL_HIGH: cond = level;
            TRIG_FALL: cond = levelPrev && !level;
            TRIG_RISE: cond = !levelPrev && level;
            default: cond = 1'b0;
        endcase
    end

    // Set wins over acknowledge; a live condition keeps the bit set
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            pending_q <= 1'b0;
        else if (allow && cond)
            pending_q <= 1'b1;
        else if (ack)
            pending_q <= 1'b0;
    end

    assign pending = pending_q;

endmodule : dio_trigger

// file: test/dio_io_ports_chk.sv
// Bus, pin and interrupt checker for the digital I/O block
module dio_io_ports_chk
    import dio_pkg::*;
#(
    parameter int unsigned CHANNELS = 8
)
(
    input wire logic core_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic [3:0] s_axi_awaddr, // Aw addr
    input wire logic s_axi_awvalid, // Aw valid
    input wire logic s_axi_awready, // Aw ready
    input wire logic [31:0] s_axi_wdata, // W data
    input wire logic [3:0] s_axi_wstrb, // W strobes
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic [1:0] s_axi_bresp, // B resp
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic [3:0] s_axi_araddr, // Ar addr
    input wire logic s_axi_arvalid, // Ar valid
    input wire logic s_axi_arready, // Ar ready
    input wire logic [31:0] s_axi_rdata, // R data
    input wire logic [1:0] s_axi_rresp, // R resp
    input wire logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready, // R ready
    input wire dio_ports_s portOut, // Driver data
    input wire dio_ports_s portOe, // Driver on
    input wire logic irq // Interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] awAddrQ;
    logic [3:0] arAddrQ;
    logic [7:0] wByteQ;
    logic wStrbQ;
    logic [1:0] maskQ;
    logic mapped;
    logic [7:0] oeSel;
    // Shadow of the last accepted addresses, write byte and interrupt mask
    always_ff @(posedge core_clk)
    begin
        if (s_axi_awvalid && s_axi_awready) awAddrQ <= s_axi_awaddr;
        if (s_axi_arvalid && s_axi_arready) arAddrQ <= s_axi_araddr;
        if (s_axi_wvalid && s_axi_wready) wByteQ <= s_axi_wdata[7:0];
        if (s_axi_wvalid && s_axi_wready) wStrbQ <= s_axi_wstrb[0];
    end
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            maskQ <= 2'h3;
        else if (s_axi_bvalid && s_axi_bready && awAddrQ == ADDR_IRQ_MASK && wStrbQ
                 && s_axi_bresp == RESP_OKAY)
            maskQ <= wByteQ[1:0];
    end
    assign mapped = arAddrQ inside {ADDR_PORT_A, ADDR_PORT_B, ADDR_PORT_C, ADDR_PORT_C_ALLOW,
        ADDR_MODE_CTRL, ADDR_PORT_C_PENDING, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
    assign oeSel = (awAddrQ == ADDR_PORT_A) ? portOe.portA :
        (awAddrQ == ADDR_PORT_B) ? portOe.portB : portOe.portC;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    chk_out_zero: assert property (portOut == '0)
        else $error("driver data not zero");
    chk_oe_latch: assert property (s_axi_bvalid && s_axi_bready && wStrbQ
        && awAddrQ <= ADDR_PORT_C |=> oeSel == ~wByteQ) else $error("driver enable wrong");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
    chk_resp_decode: assert property (s_axi_rvalid |-> s_axi_rresp == (mapped ? RESP_OKAY
        : RESP_SLVERR)) else $error("read response wrong");
    chk_pend_irq: assert property (s_axi_rvalid && arAddrQ == ADDR_PORT_C_PENDING
        && s_axi_rdata[7:0] != 8'h00 && maskQ[0] |-> irq) else $error("irq low with pending");
    chk_ext_irq: assert property (s_axi_rvalid && arAddrQ == ADDR_MODE_CTRL
        && s_axi_rdata[EXT_PENDING_BIT] && maskQ[1] |-> irq) else $error("ext irq low");
    cover property ($rose(irq));
    cover property ($fell(irq));
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : dio_io_ports_chk

bind dio_io_ports dio_io_ports_chk #(.CHANNELS(CHANNELS)) i_dio_io_ports_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .portOut(portOut), .portOe(portOe), .irq(irq)
);

// file: test/dio_pin_model.sv
// Far-side pins: pulled-up open-collector lines and an external interrupt source
module dio_pin_model
    import dio_pkg::*;
(
    input wire dio_ports_s portOe, // Block sinks line
    input wire dio_ports_s extDrive, // Outside level
    input wire logic extIrqLevel, // Source level
    output dio_ports_s portIn, // Line levels
    output logic extIrqIn // Interrupt pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up holds a line high unless either party sinks it
    assign portIn = extDrive & ~portOe;
    assign extIrqIn = extIrqLevel;
endmodule : dio_pin_model

// file: test/dio_io_ports_tb.sv
// Register-level testbench for the digital I/O block
module dio_io_ports_tb
    import dio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, extIrqLevel, extIrqIn, irq;
    dio_ports_s portIn, portOut, portOe, extDrive;
    logic [7:0] idle, d;
    int errors, compares;

    dio_io_ports #(.CHANNELS(8)) i_dio_io_ports (
        .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .portIn(portIn), .portOut(portOut), .portOe(portOe),
        .extIrqIn(extIrqIn), .irq(irq)
    );
    dio_pin_model i_dio_pin_model (.portOe(portOe), .extDrive(extDrive),
        .extIrqLevel(extIrqLevel), .portIn(portIn), .extIrqIn(extIrqIn));

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] addr, input logic [7:0] data, output logic [1:0] resp);
        @(posedge core_clk);
        s_axi_awaddr <= addr;
        s_axi_wdata <= {24'h000000, data};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] addr, output logic [7:0] data, output logic [1:0] resp);
        @(posedge core_clk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        data = s_axi_rdata[7:0];
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic put(input logic [3:0] addr, input logic [7:0] data);
        logic [1:0] resp;
        wr(addr, data, resp);
        chk("bresp", {6'h00, RESP_OKAY}, {6'h00, resp});
    endtask : put

    task automatic get(input logic [3:0] addr, input logic [7:0] exp, input string what);
        logic [7:0] data;
        logic [1:0] resp;
        rd(addr, data, resp);
        chk("rresp", {6'h00, RESP_OKAY}, {6'h00, resp});
        chk(what, exp, data);
    endtask : get

    task automatic close_out();
        $display("Counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    initial
    begin
        #100us;
        errors++;
        close_out();
    end

    initial
    begin
        errors = 0;
        compares = 0;
        sys_rst = 1'b1;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'h1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        extIrqLevel = 1'b0;
        extDrive = 24'hFFFFFF;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk("irq", 8'h00, {7'h00, irq});
        chk("portOe", 8'h00, portOe.portA | portOe.portB | portOe.portC);
        get(ADDR_PORT_A, 8'hFF, "portA");
        get(ADDR_MODE_CTRL, 8'h00, "mode");
        get(ADDR_IRQ_MASK, 8'h03, "mask");
        rd(4'h3, d, rs);
        chk("unmapped rresp", {6'h00, RESP_SLVERR}, {6'h00, rs});
        wr(4'hA, 8'hFF, rs);
        chk("unmapped bresp", {6'h00, RESP_SLVERR}, {6'h00, rs});
        $display("test reset done");
        extDrive <= '{portA: 8'hFF, portB: 8'hF3, portC: 8'h3C};
        put(ADDR_PORT_A, 8'h55);
        put(ADDR_PORT_B, 8'h5F);
        put(ADDR_PORT_C, 8'hFF);
        chk("oeA", 8'hAA, portOe.portA);
        chk("oeB", 8'hA0, portOe.portB);
        get(ADDR_PORT_A, 8'h55, "portA");
        get(ADDR_PORT_B, 8'h53, "portB");
        get(ADDR_PORT_C, 8'h3C, "portC");
        put(ADDR_PORT_A, 8'h00);
        @(negedge core_clk);
        chk("oeA", 8'hFF, portOe.portA);
        get(ADDR_PORT_A, 8'h00, "portA");
        $display("test ports done");
        for (int m = 0; m < 4; m++)
        begin
            idle = m[0] ? 8'h00 : 8'hFF;
            put(ADDR_PORT_C_ALLOW, 8'h00);
            extDrive.portC <= idle;
            put(ADDR_MODE_CTRL, {4'h0, 2'(m), 2'(m)});
            repeat (10) @(posedge core_clk);
            put(ADDR_PORT_C_PENDING, 8'hFF);
            put(ADDR_PORT_C_ALLOW, 8'hFF);
            repeat (10) @(posedge core_clk);
            get(ADDR_PORT_C_PENDING, 8'h00, "idle pending");
            extDrive.portC <= idle ^ 8'h21;
            repeat (10) @(posedge core_clk);
            get(ADDR_PORT_C_PENDING, 8'h21, "pending");
            get(ADDR_PORT_C, idle ^ 8'h21, "portC");
            chk("irq", 8'h01, {7'h00, irq});
            put(ADDR_PORT_C_PENDING, 8'h01);
            repeat (3) @(posedge core_clk);
            get(ADDR_PORT_C_PENDING, m[1] ? 8'h20 : 8'h21, "ack one");
            chk("irq", 8'h01, {7'h00, irq});
            extDrive.portC <= idle;
            repeat (10) @(posedge core_clk);
            put(ADDR_PORT_C_PENDING, 8'hFF);
            repeat (3) @(posedge core_clk);
            get(ADDR_PORT_C_PENDING, 8'h00, "ack all");
            chk("irq", 8'h00, {7'h00, irq});
        end
        $display("test port c done");
        put(ADDR_PORT_C_ALLOW, 8'h00);
        put(ADDR_MODE_CTRL, 8'h70);
        put(ADDR_IRQ_STATUS, 8'h03);
        extIrqLevel <= 1'b1;
        repeat (10) @(posedge core_clk);
        get(ADDR_MODE_CTRL, 8'hF0, "ext pending");
        chk("irq", 8'h01, {7'h00, irq});
        get(ADDR_IRQ_STATUS, 8'h02, "status");
        put(ADDR_IRQ_MASK, 8'h01);
        repeat (3) @(posedge core_clk);
        chk("masked irq", 8'h00, {7'h00, irq});
        put(ADDR_IRQ_MASK, 8'h03);
        repeat (3) @(posedge core_clk);
        chk("unmasked irq", 8'h01, {7'h00, irq});
        put(ADDR_MODE_CTRL, 8'hF0);
        repeat (3) @(posedge core_clk);
        get(ADDR_MODE_CTRL, 8'h70, "ext ack edge");
        chk("irq", 8'h00, {7'h00, irq});
        put(ADDR_IRQ_STATUS, 8'h03);
        get(ADDR_IRQ_STATUS, 8'h00, "status clear");
        put(ADDR_MODE_CTRL, 8'h50);
        repeat (10) @(posedge core_clk);
        put(ADDR_MODE_CTRL, 8'hD0);
        repeat (3) @(posedge core_clk);
        get(ADDR_MODE_CTRL, 8'hD0, "ext ack held");
        extIrqLevel <= 1'b0;
        repeat (10) @(posedge core_clk);
        put(ADDR_MODE_CTRL, 8'hD0);
        repeat (3) @(posedge core_clk);
        get(ADDR_MODE_CTRL, 8'h50, "ext ack level");
        chk("irq", 8'h00, {7'h00, irq});
        $display("test external done");
        close_out();
    end
endmodule : dio_io_ports_tb
